// [hw/rail_seq.sv]
// Purpose: sleep-state decode and rail enable sequencing with APB status
// Assumes: SRST_IN is the standby bias power-on reset
// Notes: soft-start ramps are modelled by timers, not by the capacitor
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module rail_seq
  import rail_seq_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_DLY_CYC,
  parameter int WAKE_CYC = WAKE_DLY_CYC,
  parameter int GAP_CYC = SS_GAP_CYC,
  parameter int RAMP_CYC = SS_RAMP_CYC,
  parameter int PG_CYC = VID_RAIL_GOOD_CYC
)
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // chipset sleep requests and straps
  input wire logic SUSPEND_RAM_REQ_N_IN,
  input wire logic SOFT_OFF_REQ_N_IN,
  input wire logic DUAL5_KEEP_SEL_IN,
  input wire logic AUX_RAIL_MODE_SEL_IN,
  // comparator flags and soft-start pin level
  input wire mon_t MON_IN,
  input wire logic SS_LOW_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // rail drives and reports
  output rails_t RAILS_OUT,
  output logic VID_RAIL_GOOD_OUT,
  output logic FAULT_OUT
);
  localparam int TW = 24;
  localparam int DW = 10;

  // ************************************************
  // request deglitch
  // ************************************************
  logic [1:0] raw_req; // bit0 suspend, bit1 soft-off
  logic [1:0] filt_req;
  assign raw_req = {SOFT_OFF_REQ_N_IN, SUSPEND_RAM_REQ_N_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_dgl
      logic [DW-1:0] cnt_ff; // cycles the raw level has differed
      logic [DW-1:0] nxt_cnt;
      logic lvl_ff; // filtered level, pulled-up idle high
      logic nxt_lvl;
      // a new level must persist the whole filter time to be taken
      always_comb
      begin
        nxt_lvl = lvl_ff;
        nxt_cnt = '0;
        if (raw_req[gi] != lvl_ff)
        begin
          if (cnt_ff == DW'(DEGLITCH_CYC - 1))
            nxt_lvl = raw_req[gi];
          else
            nxt_cnt = cnt_ff + 1'b1;
        end
      end
      // registers only
      always_ff @(posedge CLOCK_IN)
      begin
        if (SRST_IN)
        begin
          cnt_ff <= '0;
          lvl_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= nxt_cnt;
          lvl_ff <= nxt_lvl;
        end
      end
      assign filt_req[gi] = lvl_ff;
    end
  endgenerate

  // decoded requests; soft-off low alone matches none and holds
  logic req_act;
  logic req_s3;
  logic req_s5;
  assign req_act = filt_req[0] & filt_req[1];
  assign req_s3 = ~filt_req[0] & filt_req[1];
  assign req_s5 = ~filt_req[0] & ~filt_req[1];

  // ************************************************
  // strap capture
  // ************************************************
  logic strap_ok_ff; // straps taken once after reset
  logic keep5_ff; // 5V dual kept in soft-off
  logic lan_sel_ff; // aux rail always on
  logic nxt_strap_ok;
  logic nxt_keep5;
  logic nxt_lan_sel;
  // straps are static, so one sample after reset release suffices
  always_comb
  begin
    nxt_strap_ok = 1'b1;
    nxt_keep5 = strap_ok_ff ? keep5_ff : DUAL5_KEEP_SEL_IN;
    nxt_lan_sel = strap_ok_ff ? lan_sel_ff : AUX_RAIL_MODE_SEL_IN;
  end
  // registers only
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      strap_ok_ff <= 1'b0;
      keep5_ff <= 1'b1;
      lan_sel_ff <= 1'b1;
    end
    else
    begin
      strap_ok_ff <= nxt_strap_ok;
      keep5_ff <= nxt_keep5;
      lan_sel_ff <= nxt_lan_sel;
    end
  end

  // ************************************************
  // power state machine
  // ************************************************
  state_t st_ff;
  state_t nxt_st;
  logic [TW-1:0] tmr_ff; // shared interval timer
  logic [TW-1:0] nxt_tmr;
  logic mains_good;
  logic early_uv;
  logic sw_off_ff; // software shutdown bit
  logic shutdown;
  rails_t rails_ff;
  assign mains_good = MON_IN.main33_good & MON_IN.main5_good;
  // after the first ramp the dual and aux rails are watched for collapse
  assign early_uv = MON_IN.dual33_uv | (rails_ff.lan_rail_en & MON_IN.lan_uv);
  assign shutdown = SS_LOW_IN | sw_off_ff;

  // sequencing and state decode
  always_comb
  begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff + 1'b1;
    case (st_ff)
      // first ramp: dual 3.3V comes up after bias reset, the aux rail too only when its strap selects always-on
      ST_RAMP1:
      begin
        if (tmr_ff == TW'(RAMP_CYC - 1))
        begin
          nxt_st = ST_GAP;
          nxt_tmr = '0;
        end
      end
      // pause between ramps
      ST_GAP:
      begin
        if (early_uv)
          nxt_st = ST_LATCH;
        else if (tmr_ff == TW'(GAP_CYC - 1))
        begin
          nxt_st = ST_RAMP2;
          nxt_tmr = '0;
        end
      end
      // second ramp, then settle into whatever is requested
      ST_RAMP2:
      begin
        nxt_tmr = '0;
        if (early_uv)
          nxt_st = ST_LATCH;
        else if (tmr_ff != TW'(RAMP_CYC - 1))
          nxt_tmr = tmr_ff + 1'b1;
        else if (req_act)
          nxt_st = ST_WAKE;
        else if (req_s3)
          nxt_st = ST_S3;
        else
          nxt_st = ST_S5;
      end
      // soft-off: a suspend request alone is refused here
      ST_S5:
      begin
        nxt_tmr = '0;
        if (req_act)
          nxt_st = ST_WAKE;
      end
      // suspend-to-RAM
      ST_S3:
      begin
        nxt_tmr = '0;
        if (req_act)
          nxt_st = ST_WAKE;
        else if (req_s5)
          nxt_st = ST_S5;
      end
      // wake: timer runs only while both mains stay good
      ST_WAKE:
      begin
        // an abandoned wake never raised the active rails, so it falls back to soft-off
        if (!filt_req[0])
        begin
          nxt_st = ST_S5;
          nxt_tmr = '0;
        end
        else if (!mains_good)
          nxt_tmr = '0;
        else if (tmr_ff == TW'(WAKE_CYC - 1))
          nxt_st = ST_S0;
      end
      // active
      ST_S0:
      begin
        nxt_tmr = '0;
        if (!mains_good)
          nxt_st = ST_S5;
        else if (!filt_req[0])
          nxt_st = ST_ENTRY;
      end
      // suspend request seen: wait, then pick by soft-off request
      ST_ENTRY:
      begin
        if (!mains_good)
          nxt_st = ST_S5;
        else if (filt_req[0])
          nxt_st = ST_S0;
        else if (tmr_ff == TW'(SLEEP_CYC - 1))
          nxt_st = filt_req[1] ? ST_S3 : ST_S5;
      end
      // latched off until bias is cycled
      ST_LATCH:
      begin
        nxt_tmr = '0;
      end
      default:
      begin
        nxt_st = ST_RAMP1;
        nxt_tmr = '0;
      end
    endcase
  end
  // registers only
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      st_ff <= ST_RAMP1;
      tmr_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
    end
  end

  // ************************************************
  // rail drives, vid good and fault
  // ************************************************
  logic active;
  logic alive;
  logic mon_on;
  logic vid_off_ff; // vid regulator tripped
  logic nxt_vid_off;
  logic [TW-1:0] pg_ff; // vid good delay count
  logic [TW-1:0] nxt_pg;
  logic pg_ff_q;
  logic nxt_pg_q;
  logic fault_ff;
  logic nxt_fault;
  rails_t nxt_rails;
  assign active = (st_ff == ST_S0) | (st_ff == ST_ENTRY);
  assign alive = (st_ff != ST_LATCH) & ~shutdown;
  assign mon_on = (st_ff != ST_RAMP1) & (st_ff != ST_GAP) & (st_ff != ST_RAMP2);

  // rail enables follow the state; soft-start low overrides all
  always_comb
  begin
    nxt_rails.main_switch_gate_n = alive & active;
    nxt_rails.standby33_reg_drv = alive & ~active;
    nxt_rails.standby5_switch_drv = alive & ((st_ff == ST_S3)
      | (keep5_ff & ((st_ff == ST_S5) | (st_ff == ST_WAKE))));
    // the strap default must not light the aux rail before the strap is captured
    nxt_rails.lan_rail_en = alive & ((strap_ok_ff & lan_sel_ff) | active);
    nxt_rails.vid_reg_en = alive & active & ~vid_off_ff;
    // trip only after the rail was good, so the ramp cannot trip it
    nxt_vid_off = vid_off_ff | (rails_ff.vid_reg_en & pg_ff_q & MON_IN.vid_uv);
    if (SS_LOW_IN && !(rails_ff.vid_reg_en & pg_ff_q & MON_IN.vid_uv))
      nxt_vid_off = 1'b0;
    nxt_pg = '0;
    if (rails_ff.vid_reg_en && MON_IN.vid_good)
      nxt_pg = pg_ff_q ? pg_ff : pg_ff + 1'b1;
    nxt_pg_q = rails_ff.vid_reg_en & MON_IN.vid_good
      & (pg_ff_q | (pg_ff == TW'(PG_CYC - 1)));
    nxt_fault = (st_ff == ST_LATCH) | (st_ff != ST_LATCH) & (st_ff == ST_GAP | st_ff == ST_RAMP2) & early_uv;
    if (alive)
      nxt_fault = MON_IN.over_temp
        | (active & ~mains_good)
        | (mon_on & MON_IN.dual33_uv)
        | (mon_on & rails_ff.lan_rail_en & MON_IN.lan_uv)
        | (mon_on & (rails_ff.main_switch_gate_n | rails_ff.standby5_switch_drv) & MON_IN.dual5_uv)
        | (pg_ff_q & MON_IN.vid_uv)
        | nxt_fault;
    // overtemperature is reported even under software shutdown
    nxt_fault = nxt_fault | MON_IN.over_temp;
    if (SS_LOW_IN)
      nxt_fault = 1'b0;
  end
  // registers only
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      rails_ff <= '0;
      vid_off_ff <= 1'b0;
      pg_ff <= '0;
      pg_ff_q <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      rails_ff <= nxt_rails;
      vid_off_ff <= nxt_vid_off;
      pg_ff <= nxt_pg;
      pg_ff_q <= nxt_pg_q;
      fault_ff <= nxt_fault;
    end
  end
  assign RAILS_OUT = rails_ff;
  assign VID_RAIL_GOOD_OUT = pg_ff_q;
  assign FAULT_OUT = fault_ff;

  // ************************************************
  // apb slave
  // ************************************************
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic err_ff;
  logic nxt_err;
  logic nxt_sw_off;
  logic hit;
  // read data is captured in the setup cycle, so the answer has no wait states
  always_comb
  begin
    hit = (PADDR_IN == CTRL_OFS) | (PADDR_IN == STATUS_OFS);
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    nxt_sw_off = sw_off_ff;
    if (PSEL_IN && !PENABLE_IN)
    begin
      nxt_err = ~hit;
      nxt_rdata = '0;
      if (PADDR_IN == CTRL_OFS)
        nxt_rdata[CTRL_SWOFF_BIT] = sw_off_ff;
      else if (PADDR_IN == STATUS_OFS)
      begin
        nxt_rdata[STAT_STATE_LSB +: 9] = st_ff;
        nxt_rdata[STAT_FAULT_BIT] = fault_ff;
        nxt_rdata[STAT_VIDOFF_BIT] = vid_off_ff;
        nxt_rdata[STAT_KEEP5_BIT] = keep5_ff;
        nxt_rdata[STAT_LANSEL_BIT] = lan_sel_ff;
        nxt_rdata[STAT_VIDPG_BIT] = pg_ff_q;
      end
    end
    if (PSEL_IN && PENABLE_IN && PWRITE_IN && (PADDR_IN == CTRL_OFS))
      nxt_sw_off = PWDATA_IN[CTRL_SWOFF_BIT];
  end
  // registers only
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      rdata_ff <= '0;
      err_ff <= 1'b0;
      sw_off_ff <= CTRL_SWOFF_RST;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
      sw_off_ff <= nxt_sw_off;
    end
  end
  assign PRDATA_OUT = rdata_ff;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = err_ff & PSEL_IN & PENABLE_IN;
endmodule // rail_seq

// [hw/rail_seq_pkg.sv]
// Purpose: shared constants and types of the sleep-state rail sequencer
// Assumes: 250 MHz clock, comparator flags already synchronous
// Notes: one line per rule, tag first
package rail_seq_pkg;
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ = 250;
  localparam int DEGLITCH_NS = 2000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ) / 1000;
  localparam int SLEEP_DLY_US = 200;
  localparam int SLEEP_DLY_CYC = SLEEP_DLY_US * CLK_MHZ;
  localparam int WAKE_DLY_MS = 50;
  localparam int WAKE_DLY_CYC = WAKE_DLY_MS * 1000 * CLK_MHZ;
  localparam int SS_GAP_MS = 3;
  localparam int SS_GAP_CYC = SS_GAP_MS * 1000 * CLK_MHZ;
  localparam int SS_RAMP_US = 1000;
  localparam int SS_RAMP_CYC = SS_RAMP_US * CLK_MHZ;
  localparam int VID_RAIL_GOOD_US = 100;
  localparam int VID_RAIL_GOOD_CYC = VID_RAIL_GOOD_US * CLK_MHZ;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int CTRL_SWOFF_BIT = 0;
  localparam logic CTRL_SWOFF_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAULT_BIT = 9;
  localparam int STAT_VIDOFF_BIT = 10;
  localparam int STAT_KEEP5_BIT = 11;
  localparam int STAT_LANSEL_BIT = 12;
  localparam int STAT_VIDPG_BIT = 13;
  // ************************************************
  // types
  // ************************************************
  typedef enum logic [8:0] {
    ST_RAMP1 = 9'h001,
    ST_GAP = 9'h002,
    ST_RAMP2 = 9'h004,
    ST_S5 = 9'h008,
    ST_S3 = 9'h010,
    ST_WAKE = 9'h020,
    ST_S0 = 9'h040,
    ST_ENTRY = 9'h080,
    ST_LATCH = 9'h100
  } state_t;
  // comparator flags from the analog side
  typedef struct packed {
    logic main33_good;
    logic main5_good;
    logic dual33_uv;
    logic dual5_uv;
    logic lan_uv;
    logic vid_uv;
    logic vid_good;
    logic over_temp;
  } mon_t;
  // rail drive group
  typedef struct packed {
    logic main_switch_gate_n;
    logic standby33_reg_drv;
    logic standby5_switch_drv;
    logic lan_rail_en;
    logic vid_reg_en;
  } rails_t;
endpackage

// [tb/rail_seq_monitor.sv]
// Purpose: port-level checks of the rail sequencer
// Assumes: one clock, comparator flags already synchronous
// Notes: counters shadow the mains-good and vid-good waits
`timescale 1ns/1ps
module rail_seq_monitor
  import rail_seq_pkg::*;
#(
  parameter int WAKE_CYC = 30,
  parameter int PG_CYC = 8
)
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // causes
  input wire logic SS_LOW_IN,
  input wire mon_t MON_IN,
  // effects
  input wire rails_t RAILS_OUT,
  input wire logic VID_RAIL_GOOD_OUT,
  input wire logic FAULT_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (SRST_IN);
  // ******
  // helper counters, saturating so they never wrap
  // ******
  int mains_ff; // cycles with both mains good
  int nxt_mains;
  int vid_ff; // cycles with vid enabled and good
  int nxt_vid;
  logic mains_ok;
  assign mains_ok = MON_IN.main33_good && MON_IN.main5_good;
  // next counts
  always_comb
  begin
    nxt_mains = mains_ok ? ((mains_ff < WAKE_CYC) ? mains_ff + 1 : mains_ff) : 0;
    nxt_vid = (RAILS_OUT.vid_reg_en && MON_IN.vid_good) ? ((vid_ff < PG_CYC) ? vid_ff + 1 : vid_ff) : 0;
  end
  // registered counts
  always_ff @(posedge CLOCK_IN)
  begin
    mains_ff <= SRST_IN ? 0 : nxt_mains;
    vid_ff <= SRST_IN ? 0 : nxt_vid;
  end
  // active with a main input gone
  sequence mains_lost;
    RAILS_OUT.main_switch_gate_n && !mains_ok && !SS_LOW_IN;
  endsequence
  a_ss_shutdown: assert property (SS_LOW_IN [*3] |-> RAILS_OUT == 5'h00 && !FAULT_OUT)
    else $error("outputs not off under soft-start low");
  a_vid_only_active: assert property (RAILS_OUT.vid_reg_en |-> RAILS_OUT.main_switch_gate_n)
    else $error("vid regulator on outside active");
  a_dual_one_path: assert property (RAILS_OUT.main_switch_gate_n |-> !RAILS_OUT.standby33_reg_drv && !RAILS_OUT.standby5_switch_drv)
    else $error("standby path on while main switch released");
  a_vid_good_wait: assert property ($rose(VID_RAIL_GOOD_OUT) |-> vid_ff >= PG_CYC)
    else $error("vid good released early");
  a_vid_good_drop: assert property (!(RAILS_OUT.vid_reg_en && MON_IN.vid_good) |=> !VID_RAIL_GOOD_OUT)
    else $error("vid good held without rail");
  a_vid_trip: assert property (RAILS_OUT.vid_reg_en && VID_RAIL_GOOD_OUT && MON_IN.vid_uv && !SS_LOW_IN |-> ##2 !RAILS_OUT.vid_reg_en)
    else $error("vid regulator kept on after its undervoltage");
  a_temp_fault: assert property ((MON_IN.over_temp && !SS_LOW_IN) [*3] |-> FAULT_OUT)
    else $error("no fault on overtemperature");
  a_wake_delay: assert property ($rose(RAILS_OUT.main_switch_gate_n) |-> mains_ff >= WAKE_CYC)
    else $error("main switch released before wake delay");
  a_mains_drop: assert property (mains_lost |-> ##[1:3] !RAILS_OUT.main_switch_gate_n)
    else $error("active kept after main input loss");
  a_mains_fault: assert property (mains_lost |-> ##[0:1] FAULT_OUT)
    else $error("no fault on main input loss");
endmodule // rail_seq_monitor

bind rail_seq rail_seq_monitor #(.WAKE_CYC(WAKE_CYC), .PG_CYC(PG_CYC)) u_rail_seq_monitor (
  .CLOCK_IN(CLOCK_IN),
  .SRST_IN(SRST_IN),
  .SS_LOW_IN(SS_LOW_IN),
  .MON_IN(MON_IN),
  .RAILS_OUT(RAILS_OUT),
  .VID_RAIL_GOOD_OUT(VID_RAIL_GOOD_OUT),
  .FAULT_OUT(FAULT_OUT)
);

// [tb/chipset_model.sv]
// Purpose: chipset side driving sleep requests and board straps
// Assumes: requests launched from a register on the system clock
// Notes: lines idle high, as the pins are pulled up
`timescale 1ns/1ps
module chipset_model
(
  // clock
  input wire logic clk_in,
  // wanted levels from the sequence
  input wire logic [1:0] req_in,
  input wire logic [1:0] strap_in,
  // pins toward the sequencer
  output logic suspend_ram_req_n_out = 1'b1,
  output logic soft_off_req_n_out = 1'b1,
  output logic dual5_keep_sel_out,
  output logic aux_rail_mode_sel_out
);
  // requests leave an output register, so they move on the clock
  always @(posedge clk_in)
  begin
    suspend_ram_req_n_out <= req_in[1];
    soft_off_req_n_out <= req_in[0];
  end
  // board ties; the bench only moves them inside reset
  assign dual5_keep_sel_out = strap_in[1];
  assign aux_rail_mode_sel_out = strap_in[0];
endmodule // chipset_model

// [tb/acpi_sleep_state_rail_sequencer_tb_top.sv]
// Purpose: self-checking bench of the rail sequencer
// Assumes: short timer parameters, deglitch fixed at 500 cycles
// Notes: table rows walk the sleep states, then hand tests
`timescale 1ns/1ps
module acpi_sleep_state_rail_sequencer_tb_top;
  import rail_seq_pkg::*;
  // one table row: request levels and expected outputs
  typedef struct packed {
    logic [1:0] req;
    logic [8:0] state;
    logic vid_good;
    logic [4:0] rails;
  } row_t;
  row_t rows [9];
  logic clk, srst, ss_low, psel, penable, pwrite, pready, pslverr, vid_good, fault, er;
  logic s3n, s5n, keep, aux_rail_mode_sel;
  logic [1:0] req, strap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mon_t mon;
  rails_t rails;
  int n_fail, n_tests;
  chipset_model u_chipset_model (.clk_in(clk), .req_in(req), .strap_in(strap),
    .suspend_ram_req_n_out(s3n), .soft_off_req_n_out(s5n),
    .dual5_keep_sel_out(keep), .aux_rail_mode_sel_out(aux_rail_mode_sel));
  rail_seq #(.SLEEP_CYC(20), .WAKE_CYC(30), .GAP_CYC(10), .RAMP_CYC(10), .PG_CYC(8)) u_rail_seq (
    .CLOCK_IN(clk), .SRST_IN(srst), .SUSPEND_RAM_REQ_N_IN(s3n), .SOFT_OFF_REQ_N_IN(s5n),
    .DUAL5_KEEP_SEL_IN(keep), .AUX_RAIL_MODE_SEL_IN(aux_rail_mode_sel), .MON_IN(mon), .SS_LOW_IN(ss_low),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .RAILS_OUT(rails), .VID_RAIL_GOOD_OUT(vid_good), .FAULT_OUT(fault));
  // ******
  // shared tasks
  // ******
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; waits on pready, with no bound of its own
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // pready high ends this wait; only the watchdog bounds it
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // straps only move while reset is held
  task automatic do_reset(input logic [1:0] st, input logic [1:0] rq);
    srst <= 1'b1;
    strap <= st;
    req <= rq;
    cyc(8);
    check("reset rails", rails, 5'h00);
    srst <= 1'b0;
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short well past the planned run
  initial
  begin
    cyc(20000);
    n_fail++;
    give_verdict();
  end
  // ******
  // main sequence
  // ******
  initial
  begin
    {srst, ss_low, psel, penable, pwrite} = 5'h10;
    mon = mon_t'(8'hC2);
    req = 2'h3;
    strap = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    n_tests = 0;
    // rows: {suspend_n, soft_off_n}, state, vid good, rails
    rows = '{'{2'h3, 9'h040, 1'b1, 5'h13}, '{2'h0, 9'h008, 1'b0, 5'h0E}, '{2'h2, 9'h008, 1'b0, 5'h0E},
      '{2'h3, 9'h040, 1'b1, 5'h13}, '{2'h2, 9'h040, 1'b1, 5'h13}, '{2'h1, 9'h010, 1'b0, 5'h0E},
      '{2'h0, 9'h008, 1'b0, 5'h0E}, '{2'h1, 9'h008, 1'b0, 5'h0E}, '{2'h3, 9'h040, 1'b1, 5'h13}};
    do_reset(2'h3, 2'h3);
    foreach (rows[i])
    begin
      req <= rows[i].req;
      cyc(600);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("state", rd[8:0], rows[i].state);
      check("rails", rails, rows[i].rails);
      check("vid good", vid_good, rows[i].vid_good);
    end
    // a pulse one cycle short of the filter is ignored
    req <= 2'h1;
    cyc(499);
    req <= 2'h3;
    cyc(600);
    check("glitch", rails, 5'h13);
    mon.over_temp <= 1'b1;
    cyc(4);
    check("temp fault", fault, 1'b1);
    mon.over_temp <= 1'b0;
    cyc(4);
    check("fault clear", fault, 1'b0);
    // main 5V input lost, then back
    mon.main5_good <= 1'b0;
    cyc(8);
    apb(1'b0, STATUS_OFS, 32'h0);
    // soft-off lasts one cycle, then the wake waits for the mains with soft-off rails
    check("mains lost", rd[8:0], 9'h020);
    check("mains lost rails", rails, 5'h0E);
    mon.main5_good <= 1'b1;
    cyc(60);
    check("mains back", rails, 5'h13);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
    cyc(4);
    check("sw shutdown", rails, 5'h00);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl read", rd[0], 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    // vid undervoltage after good: fault, then the regulator stays off
    cyc(20);
    mon.vid_uv <= 1'b1;
    cyc(2);
    check("vid trip fault", fault, 1'b1);
    cyc(2);
    check("vid trip rails", rails, 5'h12);
    mon.vid_uv <= 1'b0;
    cyc(4);
    check("vid trip held", rails, 5'h12);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("vid trip flag", rd[10], 1'b1);
    // soft-start low with a fault pending
    mon.over_temp <= 1'b1;
    ss_low <= 1'b1;
    cyc(4);
    check("ss rails", rails, 5'h00);
    check("ss fault", fault, 1'b0);
    ss_low <= 1'b0;
    mon.over_temp <= 1'b0;
    cyc(4);
    check("vid restored", rails, 5'h13);
    // straps and requests low; the filter still reads high at ramp end, so it wakes to active, then enters soft-off
    do_reset(2'h0, 2'h0);
    cyc(600);
    check("strap low rails", rails, 5'h08);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("straps", rd[12:11], 2'h0);
    // dual rail undervoltage in the gap between ramps
    do_reset(2'h3, 2'h3);
    cyc(3);
    check("dual up", rails.standby33_reg_drv, 1'b1);
    cyc(12);
    mon.dual33_uv <= 1'b1;
    cyc(4);
    check("latch fault", fault, 1'b1);
    mon.dual33_uv <= 1'b0;
    cyc(100);
    check("latch rails", rails, 5'h00);
    check("latch held", fault, 1'b1);
    give_verdict();
  end
endmodule // acpi_sleep_state_rail_sequencer_tb_top
